/* design/aessc_defs.vh */
// Purpose: shared constants of the stream cipher codec
// Assumes: byte addresses on an 8-bit APB address
// Notes: definitions only
`ifndef AESSC_DEFS_VH
`define AESSC_DEFS_VH

// Register byte offsets
`define AESSC_CTRL 8'h00
`define AESSC_STATUS 8'h04
`define AESSC_KEY_LO 8'h10
`define AESSC_KEY_HI 8'h2C
`define AESSC_IV_LO 8'h30
`define AESSC_IV_HI 8'h3C
`define AESSC_RKD_LO 8'h40
`define AESSC_RKD_HI 8'h4C
`define AESSC_RKIDX 8'h50

// Control fields
`define AESSC_MODE_LSB 0
`define AESSC_KLEN_LSB 3
`define AESSC_START_BIT 8
`define AESSC_CTRL_RST 32'h0000_0000

// Chaining modes
`define AESSC_ECB 3'h0
`define AESSC_CBC 3'h1
`define AESSC_CFB 3'h2
`define AESSC_OFB 3'h3
`define AESSC_CTR 3'h4

// Key length codes: 128, 192, 256 bits
`define AESSC_K128 2'h0
`define AESSC_K192 2'h1
`define AESSC_K256 2'h2

// Round timing: rounds = base + 2 * code, words = 4 * (rounds + 1)
`define AESSC_NR_BASE 4'hA
`define AESSC_WORDS_BASE 6'h2C
`define AESSC_RCON_INIT 8'h01

`endif

/* design/aessc_sbox.v */
// Purpose: forward or inverse byte substitution
// Assumes: purely combinational, computed not tabled
// Notes: inverse in GF(2^8) by raising to the 254th power
`timescale 1ns/1ns
`default_nettype none
module aessc_sbox (
  // Byte path
  input wire [7:0] din,
  input wire inv,
  output wire [7:0] dout
);

  // Field multiply modulo the cipher polynomial
  function [7:0] gf_mul;
    input [7:0] a;
    input [7:0] b;
    reg [7:0] p;
    reg [7:0] x;
    integer k;
    begin
      p = 8'h00;
      x = a;
      for (k = 0; k < 8; k = k + 1) begin
        if (b[k])
          p = p ^ x;
        x = {x[6:0], 1'b0} ^ (x[7] ? 8'h1B : 8'h00);
      end
      gf_mul = p;
    end
  endfunction

  // x^254 is the inverse, and maps zero to zero as required
  function [7:0] gf_inv;
    input [7:0] a;
    reg [7:0] sq;
    reg [7:0] r;
    integer k;
    begin
      sq = a;
      r = 8'h01;
      for (k = 1; k < 8; k = k + 1) begin
        sq = gf_mul(sq, sq);
        r = gf_mul(r, sq);
      end
      gf_inv = r;
    end
  endfunction

  wire [7:0] pre;
  wire [7:0] fin;
  wire [7:0] fwd;
  // Inverse affine ahead of inversion on the decrypt path
  assign pre = {din[6:0], din[7]} ^ {din[4:0], din[7:5]} ^ {din[1:0], din[7:2]} ^ 8'h05;
  assign fin = gf_inv(inv ? pre : din);
  assign fwd = fin ^ {fin[6:0], fin[7]} ^ {fin[5:0], fin[7:6]} ^ {fin[4:0], fin[7:5]}
    ^ {fin[3:0], fin[7:4]} ^ 8'h63;
  assign dout = inv ? fin : fwd;
endmodule
`default_nettype wire

/* design/aessc_top.v */
// Purpose: block cipher codec for a stream of 128-bit blocks, APB control
// Assumes: one clock; feeder and consumer logic share it
// Notes: one round per cycle; results pass a two-entry output buffer
//
// Summary of operation
// - Encrypt and decrypt bit-exact to the published block cipher standard.
// - Key length of 128, 192 or 256 bits chosen at run time.
// - Chaining modes ECB, CBC, CFB, OFB and CTR selectable at run time.
// - Wide build finishes a block in 11, 13 or 15 cycles.
// - Compact 32-bit build would take 44, 52 or 60 cycles.
// - Data buses are 128 bits wide here; compact build would use 32.
// - Round keys are in the table before any block starts.
// - Table holds forward keys and their inverse-mixed decryption keys.
// - Key expander fills table entries 0 to 10, 12 or 14 from the cipher key unaided.
// - Stored keys serve every block until a new key is expanded.
// - Key size and direction sampled per block, changeable at no cost.
// - Consumer may stall output at any time without losing results.
// - Feeder may withhold input for any time; processing resumes cleanly.
// - Input refused while busy, including while a finished block waits for buffer room.
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "aessc_defs.vh"
module aessc_top #(
  parameter DW = 128, // Wide build only; no 32-bit datapath variant
  parameter AW = 1
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Input stream
  input wire [DW-1:0] in_data,
  input wire [1:0] in_keylen,
  input wire in_decrypt,
  input wire in_valid,
  output wire in_ready,
  // Output stream
  output wire [DW-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  localparam DEPTH = 1 << AW;

  // Column mix, forward or inverse
  function [7:0] gm;
    input [7:0] a;
    input [3:0] b;
    reg [7:0] p;
    reg [7:0] x;
    integer k;
    begin
      p = 8'h00;
      x = a;
      for (k = 0; k < 4; k = k + 1) begin
        if (b[k])
          p = p ^ x;
        x = {x[6:0], 1'b0} ^ (x[7] ? 8'h1B : 8'h00);
      end
      gm = p;
    end
  endfunction

  function [31:0] mixcol;
    input [31:0] c;
    input inv;
    reg [3:0] m;
    reg [7:0] acc;
    integer i;
    integer k;
    begin
      mixcol = 32'h0000_0000;
      for (i = 0; i < 4; i = i + 1) begin
        acc = 8'h00;
        for (k = 0; k < 4; k = k + 1) begin
          case (k)
            0: m = inv ? 4'hE : 4'h2;
            1: m = inv ? 4'hB : 4'h3;
            2: m = inv ? 4'hD : 4'h1;
            default: m = inv ? 4'h9 : 4'h1;
          endcase
          acc = acc ^ gm(c[31-8*((i+k)%4) -: 8], m);
        end
        mixcol[31-8*i -: 8] = acc;
      end
    end
  endfunction

  function [127:0] mixall;
    input [127:0] s;
    input inv;
    integer c;
    begin
      for (c = 0; c < 4; c = c + 1)
        mixall[127-32*c -: 32] = mixcol(s[127-32*c -: 32], inv);
    end
  endfunction

  // Row rotation; byte n is row n%4 of column n/4
  function [127:0] shiftr;
    input [127:0] s;
    input inv;
    integer r;
    integer c;
    integer src;
    begin
      for (c = 0; c < 4; c = c + 1) begin
        for (r = 0; r < 4; r = r + 1) begin
          src = inv ? (c - r + 4) % 4 : (c + r) % 4;
          shiftr[127-8*(r+4*c) -: 8] = s[127-8*(r+4*src) -: 8];
        end
      end
    end
  endfunction

  // Control and key registers
  reg [31:0] ctrl_reg;
  reg [255:0] key_reg;
  reg [127:0] rkd_reg;
  reg [127:0] chain_reg;
  reg keys_ok_reg;
  // Round key tables, forward and inverse
  reg [127:0] rk_fwd [0:14];
  reg [127:0] rk_inv [0:14];
  // Datapath state
  reg busy_reg;
  reg [3:0] rnd_reg;
  reg [3:0] nr_reg;
  reg dec_reg;
  reg udec_reg;
  reg [2:0] mode_reg;
  reg [127:0] st_reg;
  reg [127:0] din_reg;
  // Key expander state
  reg exp_busy_reg;
  reg [5:0] exp_i_reg;
  reg [2:0] exp_j_reg;
  reg [1:0] exp_kl_reg;
  reg [7:0] rcon_reg;
  reg [255:0] hist_reg;
  reg [95:0] acc_reg;
  // Output buffer
  reg [DW-1:0] fifo_mem [0:DEPTH-1];
  reg [AW-1:0] wp_reg;
  reg [AW-1:0] rp_reg;
  reg [AW:0] cnt_reg;

  // APB decode
  wire wr_acc = psel & penable & pwrite;
  wire in_key = (paddr >= `AESSC_KEY_LO) && (paddr <= `AESSC_KEY_HI);
  wire in_iv = (paddr >= `AESSC_IV_LO) && (paddr <= `AESSC_IV_HI);
  wire in_rkd = (paddr >= `AESSC_RKD_LO) && (paddr <= `AESSC_RKD_HI);
  wire mapped = (paddr == `AESSC_CTRL) || (paddr == `AESSC_STATUS) || in_key || in_iv
    || in_rkd || (paddr == `AESSC_RKIDX);
  wire [7:0] key_off = paddr - `AESSC_KEY_LO;
  wire [2:0] key_idx = key_off[4:2];
  wire [1:0] wsel = paddr[3:2];
  wire rkidx_wr = wr_acc && (paddr == `AESSC_RKIDX) && !exp_busy_reg;
  wire exp_start = wr_acc && (paddr == `AESSC_CTRL) && pwdata[`AESSC_START_BIT]
    && !exp_busy_reg;
  // Zero wait states; only unmapped offsets fail
  assign pready = 1'b1;
  assign pslverr = psel & penable & !mapped;

  // Key material reads back as zero so it cannot leak
  reg [31:0] rd_next;
  always @* begin
    rd_next = 32'h0000_0000;
    if (paddr == `AESSC_CTRL)
      rd_next = {ctrl_reg[31:9], 1'b0, ctrl_reg[7:0]};
    else if (paddr == `AESSC_STATUS)
      rd_next = {{(28-AW){1'b0}}, cnt_reg, busy_reg, exp_busy_reg, keys_ok_reg};
    else if (in_iv)
      rd_next = chain_reg[127-32*wsel -: 32];
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
      prdata <= rd_next;
  end

  // Software-held settings
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `AESSC_CTRL_RST;
      key_reg <= 256'h0;
      rkd_reg <= 128'h0;
    end else if (wr_acc) begin
      if (paddr == `AESSC_CTRL)
        ctrl_reg <= {23'h0, 1'b0, 3'h0, pwdata[4:0]};
      if (in_key)
        key_reg[255-32*key_idx -: 32] <= pwdata;
      if (in_rkd)
        rkd_reg[127-32*wsel -: 32] <= pwdata;
    end
  end

  // Key expander, one word per cycle
  wire [3:0] exp_nk = 4'h4 + {1'b0, exp_kl_reg, 1'b0};
  wire [5:0] exp_total = `AESSC_WORDS_BASE + {1'b0, exp_kl_reg, 3'h0};
  wire [31:0] prev_w = hist_reg[31:0];
  reg [31:0] old_w;
  always @* begin
    case (exp_kl_reg)
      `AESSC_K192: old_w = hist_reg[191:160];
      `AESSC_K256: old_w = hist_reg[255:224];
      default: old_w = hist_reg[127:96];
    endcase
  end
  wire rot_step = (exp_j_reg == 3'h0);
  wire [31:0] sub_in = rot_step ? {prev_w[23:0], prev_w[31:24]} : prev_w;
  wire [31:0] sub_w;
  wire [31:0] temp_w = rot_step ? (sub_w ^ {rcon_reg, 24'h0})
    : ((exp_kl_reg == `AESSC_K256) && (exp_j_reg == 3'h4)) ? sub_w : prev_w;
  wire from_key = (exp_i_reg < {2'b00, exp_nk});
  wire [31:0] new_w = from_key ? key_reg[255-32*exp_i_reg[2:0] -: 32] : (old_w ^ temp_w);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exp_busy_reg <= 1'b0;
      exp_i_reg <= 6'h00;
      exp_j_reg <= 3'h0;
      exp_kl_reg <= `AESSC_K128;
      rcon_reg <= `AESSC_RCON_INIT;
      hist_reg <= 256'h0;
      acc_reg <= 96'h0;
    end else if (exp_start) begin
      exp_busy_reg <= 1'b1;
      exp_i_reg <= 6'h00;
      exp_j_reg <= 3'h0;
      exp_kl_reg <= pwdata[`AESSC_KLEN_LSB+1:`AESSC_KLEN_LSB];
      rcon_reg <= `AESSC_RCON_INIT;
    end else if (exp_busy_reg) begin
      hist_reg <= {hist_reg[223:0], new_w};
      acc_reg <= {acc_reg[63:0], new_w};
      exp_i_reg <= exp_i_reg + 6'h01;
      exp_j_reg <= (exp_j_reg == exp_nk[2:0] - 3'h1) ? 3'h0 : exp_j_reg + 3'h1;
      if (!from_key && rot_step)
        rcon_reg <= {rcon_reg[6:0], 1'b0} ^ (rcon_reg[7] ? 8'h1B : 8'h00);
      if (exp_i_reg == exp_total - 6'h01)
        exp_busy_reg <= 1'b0;
    end
  end

  // Table write: expander has the port while running
  wire tw_en = exp_busy_reg ? (exp_i_reg[1:0] == 2'h3) : rkidx_wr;
  wire [3:0] tw_idx = exp_busy_reg ? exp_i_reg[5:2] : pwdata[3:0];
  wire [127:0] tw_data = exp_busy_reg ? {acc_reg, new_w} : rkd_reg;
  always @(posedge pclk) begin
    if (tw_en && (tw_idx < 4'hF)) begin
      rk_fwd[tw_idx] <= tw_data;
      rk_inv[tw_idx] <= mixall(tw_data, 1'b1);
    end
  end

  // Keys stay valid until a fresh expansion begins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      keys_ok_reg <= 1'b0;
    else if (exp_start)
      keys_ok_reg <= 1'b0;
    else if ((exp_busy_reg && (exp_i_reg == exp_total - 6'h01)) || rkidx_wr)
      keys_ok_reg <= 1'b1;
  end

  // Substitution boxes: sixteen for the state, four for the expander
  wire [127:0] sb_out;
  genvar g;
  generate
    for (g = 0; g < 20; g = g + 1) begin : g_sbox
      if (g < 16) begin : g_data
        aessc_sbox u_sb (
          .din(st_reg[127-8*g -: 8]),
          .inv(dec_reg),
          .dout(sb_out[127-8*g -: 8])
        );
      end else begin : g_key
        aessc_sbox u_sb (
          .din(sub_in[31-8*(g-16) -: 8]),
          .inv(1'b0),
          .dout(sub_w[31-8*(g-16) -: 8])
        );
      end
    end
  endgenerate

  // One round per cycle; decryption uses the equivalent inverse order
  wire last = (rnd_reg == nr_reg);
  wire [127:0] rkey = !dec_reg ? rk_fwd[rnd_reg]
    : (last ? rk_fwd[0] : rk_inv[nr_reg - rnd_reg]);
  wire [127:0] shifted = shiftr(sb_out, dec_reg);
  wire [127:0] rnd_res = (last ? shifted : mixall(shifted, dec_reg)) ^ rkey;

  // Block start: mode picks the cipher input and the core direction
  wire [2:0] md = (ctrl_reg[2:0] > `AESSC_CTR) ? `AESSC_ECB : ctrl_reg[2:0];
  wire blk_mode = (md == `AESSC_ECB) || (md == `AESSC_CBC);
  wire dec_eff = in_decrypt && blk_mode;
  wire [127:0] pre = (md == `AESSC_ECB) ? in_data
    : (md == `AESSC_CBC) ? (in_decrypt ? in_data : in_data ^ chain_reg) : chain_reg;
  wire [3:0] nr_in = `AESSC_NR_BASE + {1'b0, in_keylen, 1'b0};
  wire [127:0] k0 = dec_eff ? rk_fwd[nr_in] : rk_fwd[0];

  // Busy, missing keys or expansion holds the feeder off; a full buffer acts only by keeping busy set
  wire fifo_room = (cnt_reg != DEPTH);
  assign in_ready = !busy_reg && keys_ok_reg && !exp_busy_reg;
  wire accept = in_valid && in_ready;
  wire push = busy_reg && last && fifo_room;
  wire pop = out_valid && out_ready;

  // Mode post-processing of the finished block
  reg [127:0] out_w;
  reg [127:0] chain_nx;
  always @* begin
    out_w = din_reg ^ rnd_res;
    chain_nx = chain_reg;
    case (mode_reg)
      `AESSC_ECB: out_w = rnd_res;
      `AESSC_CBC: begin
        out_w = udec_reg ? rnd_res ^ chain_reg : rnd_res;
        chain_nx = udec_reg ? din_reg : rnd_res;
      end
      `AESSC_CFB: chain_nx = udec_reg ? din_reg : din_reg ^ rnd_res;
      `AESSC_OFB: chain_nx = rnd_res;
      `AESSC_CTR: chain_nx = chain_reg + 128'h1;
      default: out_w = rnd_res;
    endcase
  end

  // Sequencer: load cycle then nr rounds gives 11, 13 or 15 cycles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
      rnd_reg <= 4'h0;
      nr_reg <= `AESSC_NR_BASE;
      dec_reg <= 1'b0;
      udec_reg <= 1'b0;
      mode_reg <= `AESSC_ECB;
    end else if (accept) begin
      busy_reg <= 1'b1;
      rnd_reg <= 4'h1;
      nr_reg <= nr_in;
      dec_reg <= dec_eff;
      udec_reg <= in_decrypt;
      mode_reg <= md;
    end else if (busy_reg) begin
      if (!last)
        rnd_reg <= rnd_reg + 4'h1;
      else if (fifo_room)
        busy_reg <= 1'b0;
    end
  end

  // Data state needs no reset
  always @(posedge pclk) begin
    if (accept) begin
      st_reg <= pre ^ k0;
      din_reg <= in_data;
    end else if (busy_reg && !last) begin
      st_reg <= rnd_res;
    end
  end

  // Chaining value: block results win over a software write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      chain_reg <= 128'h0;
    else if (push)
      chain_reg <= chain_nx;
    else if (wr_acc && in_iv)
      chain_reg[127-32*wsel -: 32] <= pwdata;
  end

  // Two-entry output buffer
  always @(posedge pclk) begin
    if (push)
      fifo_mem[wp_reg] <= out_w[DW-1:0];
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_reg <= {AW{1'b0}};
      rp_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wp_reg <= wp_reg + 1'b1;
      if (pop)
        rp_reg <= rp_reg + 1'b1;
      if (push && !pop)
        cnt_reg <= cnt_reg + 1'b1;
      else if (pop && !push)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // Data held in flops until the consumer takes it
  assign out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign out_data = fifo_mem[rp_reg];
endmodule
`default_nettype wire

/* bench/aessc_checker.sv */
// Purpose: temporal checks on the codec stream and key ports
// Assumes: one clock; round keys loaded over APB
// Notes: bound into aessc_top at the foot of this file
`timescale 1ns/1ns
`default_nettype none
`include "aessc_defs.vh"
module aessc_checker #(
  parameter DW = 128,
  parameter AW = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Input stream
  input wire logic [DW-1:0] in_data,
  input wire logic [1:0] in_keylen,
  input wire logic in_decrypt,
  input wire logic in_valid,
  input wire logic in_ready,
  // Output stream
  input wire logic [DW-1:0] out_data,
  input wire logic out_valid,
  input wire logic out_ready
);
  // Handshakes and key table writes
  wire take = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire wr_key = psel & penable & pwrite &
    ((paddr == `AESSC_CTRL & pwdata[`AESSC_START_BIT]) | paddr == `AESSC_RKIDX);
  // Only a start write runs the expander; a table-index write must not count here
  wire wr_start = psel & penable & pwrite & (paddr == `AESSC_CTRL) & pwdata[`AESSC_START_BIT];
  reg keyed_reg;
  reg [3:0] pend_reg;
  // Key load seen, blocks in flight; counts only, so no data compare needed here
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keyed_reg <= 1'b0;
      pend_reg <= 4'h0;
    end else begin
      keyed_reg <= keyed_reg | wr_key;
      pend_reg <= pend_reg + {3'h0, take} - {3'h0, pop};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_lat128;
    take && !out_valid && in_keylen == `AESSC_K128
      |=> !out_valid [*8] ##2 !out_valid ##1 out_valid;
  endproperty
  a_lat128: assert property (p_lat128) else $error("short key latency wrong");
  property p_lat192;
    take && !out_valid && in_keylen == `AESSC_K192 |-> ##12 !out_valid ##1 out_valid;
  endproperty
  a_lat192: assert property (p_lat192) else $error("middle key latency wrong");
  property p_lat256;
    take && !out_valid && in_keylen == `AESSC_K256 |-> ##14 !out_valid ##1 out_valid;
  endproperty
  a_lat256: assert property (p_lat256) else $error("long key latency wrong");
  property p_busy;
    take |=> !in_ready [*8] ##1 !in_ready ##1 !in_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("input taken while busy");
  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_data);
  endproperty
  a_hold: assert property (p_hold) else $error("result lost under stall");
  property p_keys;
    in_ready |-> keyed_reg;
  endproperty
  a_keys: assert property (p_keys) else $error("input ready before keys");
  property p_expand;
    wr_start |=> !in_ready [*8];
  endproperty
  a_expand: assert property (p_expand) else $error("input ready while expanding");
  property p_gap;
    take && !out_valid && in_keylen == `AESSC_K128 |-> ##11 in_ready;
  endproperty
  a_gap: assert property (p_gap) else $error("next block not taken on time");
  property p_order;
    out_valid |-> pend_reg != 4'h0;
  endproperty
  a_order: assert property (p_order) else $error("result without input");
  c_long: cover property (take && in_keylen == `AESSC_K256);
  c_stall: cover property (out_valid && !out_ready ##1 pop);
  c_key: cover property (wr_key);
endmodule
bind aessc_top aessc_checker #(.DW(DW), .AW(AW)) u_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .in_data(in_data), .in_keylen(in_keylen), .in_decrypt(in_decrypt), .in_valid(in_valid),
  .in_ready(in_ready), .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready)
);
`default_nettype wire

/* bench/aessc_sink.sv */
// Purpose: downstream consumer of codec results
// Assumes: same clock as the codec
// Notes: stall input lets the bench pause it at will
`timescale 1ns/1ns
`default_nettype none
module aessc_sink #(
  parameter DW = 128
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Result stream
  input wire logic [DW-1:0] out_data,
  input wire logic out_valid,
  output logic out_ready,
  // Bench control
  input wire logic stall,
  output logic [4:0] rx_cnt
);
  logic [DW-1:0] rx_mem [0:31];
  // Ready is stall inverted a cycle late; a word counts only on both high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ready <= 1'b0;
      rx_cnt <= 5'h00;
    end else begin
      out_ready <= !stall;
      if (out_valid && out_ready) begin
        rx_mem[rx_cnt] <= out_data;
        rx_cnt <= rx_cnt + 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* bench/aes_stream_codec_bench.sv */
// Purpose: self-checking bench for the stream codec
// Assumes: standard known-answer blocks for the three key sizes
// Notes: results collected by aessc_sink
`timescale 1ns/1ns
`default_nettype none
`include "aessc_defs.vh"
module aes_stream_codec_bench;
  localparam logic [127:0] P = 128'h00112233445566778899AABBCCDDEEFF;
  localparam logic [127:0] V = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
  localparam logic [127:0] K0 = 128'h000102030405060708090A0B0C0D0E0F;
  logic [127:0] ct [0:2];
  logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stall = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, rerr, in_ready, out_valid, out_ready;
  logic [127:0] in_data = 128'h0, out_data;
  logic [1:0] in_keylen = 2'h0;
  logic in_decrypt = 1'b0, in_valid = 1'b0;
  logic [4:0] rx_cnt;
  int error_cnt = 0, compares = 0, rd_idx = 0;
  aessc_top #(.DW(128), .AW(1)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_data(in_data), .in_keylen(in_keylen), .in_decrypt(in_decrypt),
    .in_valid(in_valid), .in_ready(in_ready), .out_data(out_data),
    .out_valid(out_valid), .out_ready(out_ready)
  );
  aessc_sink #(.DW(128)) sink (
    .pclk(pclk), .presetn(presetn), .out_data(out_data), .out_valid(out_valid),
    .out_ready(out_ready), .stall(stall), .rx_cnt(rx_cnt)
  );
  // 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // One APB transfer; request held until pready seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Feeder holds block and controls until taken
  task automatic send(input logic [127:0] d, input logic [1:0] kl, input logic dec);
    @(posedge pclk);
    in_data <= d;
    in_keylen <= kl;
    in_decrypt <= dec;
    in_valid <= 1'b1;
    do @(posedge pclk); while (in_ready !== 1'b1);
    in_valid <= 1'b0;
  endtask
  task automatic recv(input logic [127:0] exp);
    int n;
    n = 0;
    while (int'(rx_cnt) <= rd_idx && n < 400) begin
      @(posedge pclk);
      n++;
    end
    check(sink.rx_mem[rd_idx], exp);
    rd_idx++;
  endtask
  // Key words 00010203.. then expansion, polled with a bound
  task automatic load_key(input logic [1:0] kl);
    int n;
    n = 0;
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `AESSC_KEY_LO + 8'(4 * i), 32'h00010203 + 32'h04040404 * 32'(i));
    end
    apb(1'b1, `AESSC_CTRL, {23'h0, 1'b1, 3'h0, kl, `AESSC_ECB});
    do begin
      apb(1'b0, `AESSC_STATUS, 32'h0);
      n++;
    end while (rdata[0] !== 1'b1 && n < 100);
    check({127'h0, rdata[0]}, 128'h1);
  endtask
  task automatic run_mode(input logic [2:0] m, input logic [127:0] iv, input logic [127:0] d,
      input logic dec, input logic [127:0] exp);
    apb(1'b1, `AESSC_CTRL, {27'h0, `AESSC_K256, m});
    for (int i = 0; i < 4; i++) apb(1'b1, `AESSC_IV_LO + 8'(4 * i), iv[127 - 32 * i -: 32]);
    send(d, `AESSC_K256, dec);
    recv(exp);
  endtask
  // Hang guard well beyond the expected run
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    print_verdict();
  end
  initial begin
    ct[0] = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
    ct[1] = 128'hDDA97CA4864CDFE06EAF70A0EC0D7191;
    ct[2] = 128'h8EA2B7CA516745BFEAFC49904B496089;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `AESSC_STATUS, 32'h0);
    check({96'h0, rdata}, 128'h0);
    check({127'h0, in_ready}, 128'h0);
    apb(1'b0, 8'h08, 32'h0);
    check({95'h0, rerr, rdata}, {95'h0, 1'b1, 32'h0});
    // Each key size, encrypt then decrypt back to back
    for (int k = 0; k < 3; k++) begin
      load_key(2'(k));
      send(P, 2'(k), 1'b0);
      send(ct[k], 2'(k), 1'b1);
      recv(ct[k]);
      recv(P);
    end
    // Chaining modes, picked so the answer is a known block
    run_mode(`AESSC_CBC, V, P ^ V, 1'b0, ct[2]);
    send(P ^ ct[2], `AESSC_K256, 1'b0);
    recv(ct[2]);
    run_mode(`AESSC_CBC, V, ct[2], 1'b1, P ^ V);
    run_mode(`AESSC_CFB, P, 128'h0, 1'b0, ct[2]);
    run_mode(`AESSC_CFB, P, ct[2], 1'b1, 128'h0);
    run_mode(`AESSC_OFB, P, 128'h0, 1'b0, ct[2]);
    run_mode(`AESSC_CTR, P, ct[2], 1'b0, 128'h0);
    apb(1'b0, `AESSC_IV_HI, 32'h0);
    check({96'h0, rdata}, {96'h0, 32'hCCDDEF00});
    // Long feeder silence, then consumer stall fills the buffer
    apb(1'b1, `AESSC_CTRL, {27'h0, `AESSC_K256, `AESSC_ECB});
    // Software table write: swap key 0, compensate in the data, then restore it
    for (int i = 0; i < 4; i++) apb(1'b1, `AESSC_RKD_LO + 8'(4 * i), V[127 - 32 * i -: 32]);
    apb(1'b1, `AESSC_RKIDX, 32'h0);
    send(P ^ V ^ K0, `AESSC_K256, 1'b0);
    recv(ct[2]);
    for (int i = 0; i < 4; i++) apb(1'b1, `AESSC_RKD_LO + 8'(4 * i), K0[127 - 32 * i -: 32]);
    apb(1'b1, `AESSC_RKIDX, 32'h0);
    repeat (50) @(posedge pclk);
    stall <= 1'b1;
    repeat (3) send(P, `AESSC_K256, 1'b0);
    repeat (40) @(posedge pclk);
    check({127'h0, in_ready}, 128'h0);
    stall <= 1'b0;
    send(P, `AESSC_K256, 1'b0);
    repeat (4) recv(ct[2]);
    print_verdict();
  end
endmodule
`default_nettype wire
